// ===== logic/cbbc_pkg.sv
package cbbc_pkg;
  localparam int          NUM_SOCKETS        = 2;
  localparam int          REG_W              = 16;
  localparam int          ADDR_W             = 8;

  // Configuration offsets (byte address of the 16-bit register)
  localparam logic [7:0]  BRIDGE_CTRL_OFFSET = 8'h3E;
  localparam logic [7:0]  SUBSYS_VEND_OFFSET = 8'h40;

  // Bridge control field positions
  localparam int          BIT_PARITY_RESP    = 0;
  localparam int          BIT_SYSERR_FWD     = 1;
  localparam int          BIT_ISA_FILTER     = 2;
  localparam int          BIT_VGA_FWD        = 3;
  localparam int          BIT_MABORT_MODE    = 5;
  localparam int          BIT_CARD_RESET     = 6;
  localparam int          BIT_IRQ_ROUTE      = 7;
  localparam int          BIT_WIN0_PREFETCH  = 8;
  localparam int          BIT_WIN1_PREFETCH  = 9;
  localparam int          BIT_WRITE_POST     = 10;

  // Reset values and masks
  localparam logic [15:0] BRIDGE_CTRL_RESET  = 16'h0340;
  localparam logic [15:0] BRIDGE_CTRL_WMASK  = 16'h07EF;
  localparam logic [15:0] SOCKET_BITS_MASK   = 16'h07CF;
  localparam logic [15:0] SHARED_BITS_MASK   = 16'h0020;
  localparam logic [15:0] SUBSYS_VEND_RESET  = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED      = 16'h0000;

  // ISA alias window: top 768 bytes of every 1K block below 64K
  localparam logic [15:0] ISA_RANGE_TOP      = 16'h0000;
  localparam logic [1:0]  ISA_BLOCK_LOW256   = 2'h0;
endpackage

// ===== logic/cbbc_regs.sv
`timescale 1ns/100ps
// Function
// - Bits 15..11 read zero, not writable
// - Bit 10 write posting, per socket
// - Bit 9 window 1 prefetchable, resets 1
// - Bit 8 window 0 prefetchable, resets 1
// - Bit 7 routes card interrupts PCI/legacy
// - Bit 6 drives card reset, resets 1
// - PCI bus reset also asserts card reset
// - Card reset bit set by global reset, kept on bus reset
// - Context bits keep on bus reset if PME
// - Bit 5 shared master-abort reporting mode
// - Bit 4 reserved, reads zero
// - Bit 3 forwards VGA accesses
// - Bit 2 blocks ISA alias I/O, per socket
// - Bit 1 forwards card system error, per socket
// - Bit 0 reports card parity errors, per socket
// - Vendor ident writable only when unlocked
// - Vendor ident resets zero, global reset only
// - Vendor ident loaded from EEPROM after reset
module cbbc_regs (
  input  wire logic        clk_sys,                  // 100 MHz system clock
  input  wire logic        rst_b,                    // Global reset, async, active low
  input  wire logic        pciBusResetIn_b,          // PCI bus reset, active low
  input  wire logic        pmeEnable,                // Power management events enabled
  input  wire logic        subsystemWriteLock,       // Write lock, 1 = ident read-only
  input  wire logic        cfgFunc,                  // Configuration function number 0/1
  input  wire logic [7:0]  cfgAddr,                  // Configuration byte offset
  input  wire logic        cfgWrEn,                  // Write strobe, one cycle
  input  wire logic        cfgRdEn,                  // Read strobe, one cycle
  input  wire logic [1:0]  cfgByteEn,                // Byte enables of the 16-bit word
  input  wire logic [15:0] cfgWrData,                // Write data
  output logic      [15:0] cfgRdData,                // Read data, registered
  output logic             cfgRdValid,               // Read data valid pulse
  input  wire logic        eepromLoadValid,          // EEPROM ident value strobe
  input  wire logic [15:0] eepromVendorIdent,        // EEPROM ident value
  input  wire logic [1:0]  cardSystemError,          // Card system-error per socket
  input  wire logic [1:0]  cardParityDetect,         // Card parity fault per socket
  input  wire logic [1:0]  cardMasterAbort,          // Master abort seen on card bus
  input  wire logic        pciSerrEnable,            // PCI SERR enable from command
  input  wire logic        ioCycleValid,             // I/O cycle decode request
  input  wire logic        ioCycleSocket,            // Socket the I/O cycle targets
  input  wire logic [31:0] ioCycleAddr,              // I/O cycle address
  output logic             ioForwardAllowed,         // I/O cycle may go to card
  output logic [1:0]       writePostingEnable,       // Per socket write posting
  output logic [1:0]       window1Prefetchable,      // Per socket window 1 type
  output logic [1:0]       window0Prefetchable,      // Per socket window 0 type
  output logic [1:0]       cardIrqRouteSelect,       // 0 = PCI lines, 1 = legacy IRQ
  output logic [1:0]       cardBusResetOut_b,        // Card reset, active low
  output logic             masterAbortReportMode,    // Shared master abort mode
  output logic [1:0]       vgaForwardEnable,         // Per socket VGA forwarding
  output logic [1:0]       isaAliasFilterEnable,     // Per socket ISA alias filter
  output logic [1:0]       cardSyserrForwardEnable,  // Per socket system error forward
  output logic [1:0]       cardParityResponseEnable, // Per socket parity response
  output logic             pciSerrOut,               // SERR request toward PCI
  output logic             pciTargetAbortOut,        // Target abort request toward PCI
  output logic [1:0]       cardParityError,          // Parity error report per socket
  output logic [15:0]      subsystemVendorIdent      // Ident register value
);

  logic [15:0] sockCtrl_r [cbbc_pkg::NUM_SOCKETS];
  logic [15:0] sockCtrl_nxt [cbbc_pkg::NUM_SOCKETS];
  logic        sharedMabort_r;
  logic        sharedMabort_nxt;
  logic [15:0] vendIdent_r;
  logic [15:0] vendIdent_nxt;
  logic [15:0] rdData_r;
  logic        rdValid_r;
  logic [1:0]  cardRst_r;
  logic        serr_r;
  logic        tabort_r;
  logic [1:0]  parErr_r;
  logic        ioFwd_r;
  wire  [1:0]  serrTerms;
  wire  [1:0]  mabtTerms;

  wire         busResetActive = ~pciBusResetIn_b;
  wire         hitBridge      = (cfgAddr == cbbc_pkg::BRIDGE_CTRL_OFFSET);
  wire         hitVendor      = (cfgAddr == cbbc_pkg::SUBSYS_VEND_OFFSET);
  wire [15:0]  laneMask       = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};
  wire [15:0]  bridgeWrMask   = laneMask & cbbc_pkg::BRIDGE_CTRL_WMASK;
  wire         bridgeWr       = cfgWrEn & hitBridge;
  // Shared bit written only through function 0
  wire         sharedWr       = bridgeWr & ~cfgFunc
                                & bridgeWrMask[cbbc_pkg::BIT_MABORT_MODE];
  wire         vendorWr       = cfgWrEn & hitVendor & ~subsystemWriteLock;
  wire [15:0]  sharedView     = {{(cbbc_pkg::REG_W - 1){1'b0}}, sharedMabort_r} << cbbc_pkg::BIT_MABORT_MODE;
  wire [15:0]  bridgeView     = (sockCtrl_r[cfgFunc] & cbbc_pkg::SOCKET_BITS_MASK)
                                | (sharedView & cbbc_pkg::SHARED_BITS_MASK);
  wire [15:0]  rdMux          = hitBridge ? bridgeView :
                                hitVendor ? vendIdent_r : cbbc_pkg::READ_UNMAPPED;

  // Bus reset restores context bits only when PME is off; card reset bit is never touched
  wire [15:0]  busRstKeep     = pmeEnable ? 16'hFFFF
                                : (16'h0001 << cbbc_pkg::BIT_CARD_RESET);
  assign sharedMabort_nxt = sharedWr ? cfgWrData[cbbc_pkg::BIT_MABORT_MODE]
                          : (busResetActive & ~pmeEnable)
                            ? cbbc_pkg::BRIDGE_CTRL_RESET[cbbc_pkg::BIT_MABORT_MODE]
                            : sharedMabort_r;

  // EEPROM load takes precedence over a host write in the same cycle
  assign vendIdent_nxt = eepromLoadValid ? eepromVendorIdent
                       : vendorWr ? ((vendIdent_r & ~laneMask) | (cfgWrData & laneMask))
                       : vendIdent_r;

  genvar s;
  generate
    for (s = 0; s < cbbc_pkg::NUM_SOCKETS; s++) begin : gSock
      wire        sockWr   = bridgeWr & (cfgFunc == 1'(s));
      wire [15:0] wrMask   = bridgeWrMask & cbbc_pkg::SOCKET_BITS_MASK;
      wire [15:0] afterRst = busResetActive
                             ? ((sockCtrl_r[s] & busRstKeep)
                               | (cbbc_pkg::BRIDGE_CTRL_RESET & ~busRstKeep))
                             : sockCtrl_r[s];
      wire        sockSerr  = cardSystemError[s] & sockCtrl_r[s][cbbc_pkg::BIT_SYSERR_FWD];
      wire        sockMabt  = cardMasterAbort[s] & sharedMabort_r;

      assign sockCtrl_nxt[s] = sockWr ? ((afterRst & ~wrMask) | (cfgWrData & wrMask))
                                      : afterRst;

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sockCtrl_r[s] <= cbbc_pkg::BRIDGE_CTRL_RESET;
        end else begin
          sockCtrl_r[s] <= sockCtrl_nxt[s];
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cardRst_r[s] <= 1'b1;
          parErr_r[s]  <= 1'b0;
        end else begin
          cardRst_r[s] <= sockCtrl_r[s][cbbc_pkg::BIT_CARD_RESET] | busResetActive;
          parErr_r[s]  <= cardParityDetect[s] & sockCtrl_r[s][cbbc_pkg::BIT_PARITY_RESP];
        end
      end

      assign writePostingEnable[s]       = sockCtrl_r[s][cbbc_pkg::BIT_WRITE_POST];
      assign window1Prefetchable[s]      = sockCtrl_r[s][cbbc_pkg::BIT_WIN1_PREFETCH];
      assign window0Prefetchable[s]      = sockCtrl_r[s][cbbc_pkg::BIT_WIN0_PREFETCH];
      assign cardIrqRouteSelect[s]       = sockCtrl_r[s][cbbc_pkg::BIT_IRQ_ROUTE];
      assign vgaForwardEnable[s]         = sockCtrl_r[s][cbbc_pkg::BIT_VGA_FWD];
      assign isaAliasFilterEnable[s]     = sockCtrl_r[s][cbbc_pkg::BIT_ISA_FILTER];
      assign cardSyserrForwardEnable[s]  = sockCtrl_r[s][cbbc_pkg::BIT_SYSERR_FWD];
      assign cardParityResponseEnable[s] = sockCtrl_r[s][cbbc_pkg::BIT_PARITY_RESP];
      assign cardBusResetOut_b[s]        = ~cardRst_r[s];
      assign cardParityError[s]          = parErr_r[s];
      assign serrTerms[s]                = sockSerr;
      assign mabtTerms[s]                = sockMabt;
    end
  endgenerate

  // ISA alias: address below 64K whose offset within its 1K block is 100h..3FFh
  wire [15:0]  ioSelCtrl   = sockCtrl_r[ioCycleSocket];
  wire         ioBelow64k  = (ioCycleAddr[31:16] == cbbc_pkg::ISA_RANGE_TOP);
  wire         ioAliasHit  = ioBelow64k & (ioCycleAddr[9:8] != cbbc_pkg::ISA_BLOCK_LOW256);
  wire         ioBlocked   = ioSelCtrl[cbbc_pkg::BIT_ISA_FILTER] & ioAliasHit;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sharedMabort_r <= cbbc_pkg::BRIDGE_CTRL_RESET[cbbc_pkg::BIT_MABORT_MODE];
      vendIdent_r    <= cbbc_pkg::SUBSYS_VEND_RESET;
    end else begin
      sharedMabort_r <= sharedMabort_nxt;
      vendIdent_r    <= vendIdent_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r  <= cbbc_pkg::READ_UNMAPPED;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= cfgRdEn;
      if (cfgRdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serr_r   <= 1'b0;
      tabort_r <= 1'b0;
      ioFwd_r  <= 1'b0;
    end else begin
      serr_r   <= pciSerrEnable & ((|serrTerms) | (|mabtTerms));
      tabort_r <= |mabtTerms;
      ioFwd_r  <= ioCycleValid & ~ioBlocked;
    end
  end

  assign cfgRdData             = rdData_r;
  assign cfgRdValid            = rdValid_r;
  assign masterAbortReportMode = sharedMabort_r;
  assign pciSerrOut            = serr_r;
  assign pciTargetAbortOut     = tabort_r;
  assign ioForwardAllowed      = ioFwd_r;
  assign subsystemVendorIdent  = vendIdent_r;

endmodule

// ===== testbench/cbbc_regs_sva.sv
`timescale 1ns/100ps
module cbbc_regs_sva (
  input wire logic        clk_sys,                 // Clock
  input wire logic        rst_b,                   // Global reset
  input wire logic        pciBusResetIn_b,         // Bus reset
  input wire logic [7:0]  cfgAddr,                 // Offset
  input wire logic        cfgWrEn,                 // Write
  input wire logic        cfgRdEn,                 // Read
  input wire logic [15:0] cfgRdData,               // Read data
  input wire logic        cfgRdValid,              // Read valid
  input wire logic        subsystemWriteLock,      // Lock
  input wire logic        eepromLoadValid,         // Load strobe
  input wire logic [15:0] eepromVendorIdent,       // Load value
  input wire logic [15:0] subsystemVendorIdent,    // Ident
  input wire logic [1:0]  cardSystemError,         // Card event
  input wire logic [1:0]  cardMasterAbort,         // Card event
  input wire logic        pciSerrEnable,           // Enable
  input wire logic [1:0]  cardSyserrForwardEnable, // Field
  input wire logic        masterAbortReportMode,   // Field
  input wire logic [1:0]  cardBusResetOut_b,       // Card reset
  input wire logic        pciSerrOut,              // Report
  input wire logic        pciTargetAbortOut        // Report
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence rdBridge;
    cfgRdEn && cfgAddr == 8'h3E;
  endsequence
  sequence rdLone;
    rdBridge ##1 !cfgRdEn;
  endsequence
  rd_answer_a: assert property (rdBridge |=> cfgRdValid && cfgRdData[15:11] == 5'h00 && !cfgRdData[4])
    else $error("bridge read answer wrong");
  rd_pulse_a: assert property (rdLone |=> !cfgRdValid)
    else $error("read valid too long");
  card_rst_bus_a: assert property (!pciBusResetIn_b |=> cardBusResetOut_b == 2'h0)
    else $error("card reset not driven on bus reset");
  rst_default_a: assert property ($rose(rst_b) |-> cardBusResetOut_b == 2'h0)
    else $error("card reset not held after reset");
  abort_ta_a: assert property (pciTargetAbortOut == $past(|cardMasterAbort && masterAbortReportMode))
    else $error("target abort report wrong");
  serr_fwd_a: assert property (pciSerrOut == $past(pciSerrEnable && ((|(cardSystemError & cardSyserrForwardEnable))
    || (|cardMasterAbort && masterAbortReportMode)))) else $error("system error report wrong");
  ident_lock_a: assert property (cfgWrEn && subsystemWriteLock && !eepromLoadValid |=> $stable(subsystemVendorIdent))
    else $error("locked ident changed");
  ident_load_a: assert property (eepromLoadValid |=> subsystemVendorIdent == $past(eepromVendorIdent))
    else $error("ident load missed");
endmodule

// ===== testbench/cbbc_card_model.sv
`timescale 1ns/100ps
module cbbc_card_model (
  input  wire logic       clk_sys,          // Clock
  input  wire logic       rst_b,            // Global reset
  input  wire logic [5:0] evtReq,           // Requested events
  output logic      [1:0] cardSystemError,  // Card system error
  output logic      [1:0] cardParityDetect, // Card parity fault
  output logic      [1:0] cardMasterAbort   // Card master abort
);
  // Events move on the falling edge, clear of the sampling edge
  always_ff @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {cardSystemError, cardParityDetect, cardMasterAbort} <= 6'h00;
    end else begin
      {cardSystemError, cardParityDetect, cardMasterAbort} <= evtReq;
    end
  end
endmodule

// ===== testbench/cardbus_bridge_control_regs_tb_top.sv
`timescale 1ns/100ps
module cardbus_bridge_control_regs_tb_top;
  logic        clk_sys, rst_b, pciBusResetIn_b, pmeEnable, subsystemWriteLock, cfgFunc, cfgWrEn, cfgRdEn;
  logic        eepromLoadValid, pciSerrEnable, ioCycleValid, ioCycleSocket, cfgRdValid, ioForwardAllowed;
  logic [1:0]  cfgByteEn, cardSystemError, cardParityDetect, cardMasterAbort, cardBusResetOut_b, cardParityError;
  logic [7:0]  cfgAddr;
  logic [15:0] cfgWrData, cfgRdData, eepromVendorIdent, expVid, expBc [2];
  logic [31:0] ioCycleAddr, lf;
  logic [5:0]  evtReq;
  logic [1:0]  writePostingEnable, window1Prefetchable, window0Prefetchable, cardIrqRouteSelect;
  logic [1:0]  vgaForwardEnable, isaAliasFilterEnable, cardSyserrForwardEnable, cardParityResponseEnable;
  logic        masterAbortReportMode;
  logic [15:0] subsystemVendorIdent;
  int          errors, checks_done, cyc;
  cbbc_regs cbbc_regs_i (.*, .pciSerrOut(), .pciTargetAbortOut());
  function automatic logic [1:0] fld(int b);
    return {expBc[1][b], expBc[0][b]};
  endfunction
  cbbc_card_model cbbc_card_model_i (.*);
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(logic f, logic [7:0] a, logic [1:0] be, logic [15:0] d);
    logic [15:0] m;
    @(negedge clk_sys);
    {cfgFunc, cfgAddr, cfgByteEn, cfgWrData, cfgWrEn} = {f, a, be, d, 1'b1};
    m = {{8{be[1]}}, {8{be[0]}}};
    if (a == 8'h40 && !subsystemWriteLock) expVid = expVid & ~m | d & m;
    m = m & (f ? 16'h07CF : 16'h07EF);
    if (a == 8'h3E) expBc[f] = expBc[f] & ~m | d & m;
    expBc[!f][5] = expBc[f][5];
    @(negedge clk_sys);
    cfgWrEn = 1'b0;
  endtask
  task automatic rd(logic f, logic [7:0] a, logic [15:0] e);
    @(negedge clk_sys);
    {cfgFunc, cfgAddr, cfgRdEn} = {f, a, 1'b1};
    @(negedge clk_sys);
    cfgRdEn = 1'b0;
    cmp({15'h0000, cfgRdValid}, 16'h0001);
    cmp(cfgRdData, e);
  endtask
  task automatic chk;
    rd(1'b0, 8'h3E, expBc[0]);
    rd(1'b1, 8'h3E, expBc[1]);
    rd(1'b1, 8'h40, expVid);
    rd(1'b0, 8'h44, 16'h0000);
    cmp({writePostingEnable, window1Prefetchable, window0Prefetchable, cardIrqRouteSelect,
         vgaForwardEnable, isaAliasFilterEnable, cardSyserrForwardEnable, cardParityResponseEnable},
        {fld(10), fld(9), fld(8), fld(7), fld(3), fld(2), fld(1), fld(0)});
    cmp({15'h0000, masterAbortReportMode}, {15'h0000, expBc[0][5]});
    cmp(subsystemVendorIdent, expVid);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up;
    end
  end
  initial begin
    {rst_b, pciBusResetIn_b, pmeEnable, subsystemWriteLock, cfgFunc, cfgWrEn, cfgRdEn} = 7'h30;
    {eepromLoadValid, pciSerrEnable, ioCycleValid, ioCycleSocket, cfgAddr, cfgByteEn, evtReq} = '0;
    {cfgWrData, eepromVendorIdent, ioCycleAddr, expVid} = '0;
    expBc = '{16'h0340, 16'h0340};
    lf = 32'h08F2;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    chk;
    $display("test defaults done");
    repeat (40) begin
      lf = nxt(lf);
      {subsystemWriteLock, evtReq, pciSerrEnable} = lf[31:24];
      wr(lf[16], lf[18] ? 8'h3E : (lf[19] ? 8'h40 : 8'h44), lf[21:20], lf[15:0]);
    end
    chk;
    $display("test random done");
    wr(1'b0, 8'h3E, 2'h1, expBc[0] & 16'hFFBF);
    @(negedge clk_sys);
    cmp({14'h0000, cardBusResetOut_b}, {14'h0000, ~expBc[1][6], ~expBc[0][6]});
    pciBusResetIn_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp({14'h0000, cardBusResetOut_b}, 16'h0000);
    pciBusResetIn_b = 1'b1;
    chk;
    {pmeEnable, pciBusResetIn_b} = 2'h0;
    @(negedge clk_sys);
    pciBusResetIn_b = 1'b1;
    expBc = '{16'h0300 | expBc[0] & 16'h0040, 16'h0300 | expBc[1] & 16'h0040};
    chk;
    $display("test bus reset done");
    wr(1'b0, 8'h3E, 2'h1, 16'h0004);
    wr(1'b1, 8'h3E, 2'h1, 16'h0001);
    {evtReq, ioCycleValid, ioCycleSocket, ioCycleAddr} = {6'h0C, 2'h2, 32'h0000_0100};
    repeat (2) @(negedge clk_sys);
    cmp({14'h0000, cardParityError}, 16'h0002);
    cmp({15'h0000, ioForwardAllowed}, 16'h0000);
    ioCycleSocket = 1'b1;
    @(negedge clk_sys);
    cmp({15'h0000, ioForwardAllowed}, 16'h0001);
    $display("test events done");
    {subsystemWriteLock, eepromLoadValid, eepromVendorIdent} = {2'h3, lf[15:0]};
    @(negedge clk_sys);
    {eepromLoadValid, expVid} = {1'b0, eepromVendorIdent};
    wr(1'b0, 8'h40, 2'h3, ~lf[15:0]);
    chk;
    $display("test ident done");
    wrap_up;
  end
endmodule
bind cbbc_regs cbbc_regs_sva cbbc_regs_sva_i (.*);
